// *** hdl/wsc_map.svh ***
// constants of the weld stepper counter: register offsets, field positions, codes, timing
// assumes a 100 MHz aclk and a 32-bit AXI4-Lite register bus with byte addresses
// Function
// - in program mode, enter plus both data buttons reloads first step
// - partial button combinations leave stepper unchanged
// - after manual reload show step and count
// - step and count writable directly while the stepper is idle
// - zero on last step reads next schedule
// - reset schedule: count 0, off 99, empty
// - in program mode, enter plus program/operate clears displayed schedule
// - input function 05: terminal opening reloads stepper
// - down-counter loadable from 0 to 9999
// - weld countdown and step advance work only in mode 01 or 02; reloads work in any mode
// - show remaining count after each sequence
// - end message flashes, cleared by button or estop
// - valve on while end message flashes, codes 10/17
// - zero weld count after last step ends stepper
`ifndef WSC_MAP_SVH
`define WSC_MAP_SVH

`define WSC_A_CTRL 8'h00
`define WSC_A_STEP 8'h04
`define WSC_A_COUNT 8'h08
`define WSC_A_FIRST 8'h0c
`define WSC_A_SADDR 8'h10
`define WSC_A_SDATA 8'h14
`define WSC_A_STATUS 8'h18

`define WSC_CTRL_RST 32'h0000_0000
`define WSC_F_MODE 1:0
`define WSC_F_PROG 2
`define WSC_F_SHOWCNT 3
`define WSC_F_SSEL 14:8
`define WSC_F_INFN 23:16
`define WSC_F_POUT 31:24

`define WSC_F_WC 13:0
`define WSC_F_OFF 20:14
`define WSC_F_VALVE 28:21
`define WSC_F_OTHER 29

`define WSC_MODE_A 2'h1
`define WSC_MODE_B 2'h2
`define WSC_INFN_EXTRST 8'h05
`define WSC_POUT_END_A 8'h10
`define WSC_POUT_END_B 8'h17
`define WSC_CNT_MAX 14'h270f
`define WSC_RST_OFF 7'h63
`define WSC_RESP_OK 2'h0
`define WSC_RESP_ERR 2'h2

`define WSC_SHOW_TIME_MS 1500
`define WSC_CLK_KHZ 100000
`define WSC_SHOW_CYC (`WSC_SHOW_TIME_MS * `WSC_CLK_KHZ)

`endif

// *** hdl/wsc_pkg.sv ***
// types shared by the weld stepper counter files
// assumes wsc_map.svh supplies the numeric constants
package wsc_pkg;
	typedef struct packed {
		logic enter;
		logic data_ones;
		logic data_tens;
		logic prog_op;
		logic select;
		logic sched_step;
	} wsc_buttons_s;

	typedef struct packed {
		logic other_nz;
		logic [7:0] valves;
		logic [6:0] off_time;
		logic [13:0] weld_count;
	} wsc_sched_s;

	typedef enum logic [1:0] {
		ST_IDLE,
		ST_WAIT,
		ST_EVAL
	} wsc_state_e;
endpackage : wsc_pkg

// *** hdl/wsc_sched_mem.sv ***
// schedule memory: one write port, one read port with registered data
// assumes the caller avoids reading an address in the cycle it is written
`timescale 1ns/1ps
module wsc_sched_mem (
	input wire logic aclk,
	input wire logic we,
	input wire logic [6:0] waddr,
	input wsc_pkg::wsc_sched_s wdata,
	input wire logic [6:0] raddr,
	output wsc_pkg::wsc_sched_s rdata
);
	import wsc_pkg::*;

	wsc_sched_s mem_r [0:127];

	always_ff @(posedge aclk) begin
		if (we) begin
			mem_r[waddr] <= wdata;
		end
	end

	always_ff @(posedge aclk) begin
		rdata <= mem_r[raddr];
	end
endmodule : wsc_sched_mem

// *** hdl/wsc_edge.sv ***
// registered rise and fall pulses for a vector of synchronous levels
// assumes inputs already sit in the aclk domain
`timescale 1ns/1ps
module wsc_edge #(
	parameter int W = 8
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [W-1:0] lvl,
	input wire logic [W-1:0] rst_val,
	output logic [W-1:0] rise,
	output logic [W-1:0] fall
);
	logic [W-1:0] prev_r;
	logic init_r;

	// the first cycle after reset only captures, so a level held through reset is no edge
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			init_r <= 1'b0;
		end else begin
			init_r <= 1'b1;
		end
	end

	genvar i;
	generate
		for (i = 0; i < W; i++) begin : g_bit
			always_ff @(posedge aclk) begin
				if (!aresetn) begin
					prev_r[i] <= rst_val[i];
					rise[i] <= 1'b0;
					fall[i] <= 1'b0;
				end else begin
					prev_r[i] <= lvl[i];
					rise[i] <= init_r & lvl[i] & ~prev_r[i];
					fall[i] <= init_r & ~lvl[i] & prev_r[i];
				end
			end
		end
	endgenerate
endmodule : wsc_edge

// *** hdl/wsc_top.sv ***
// weld stepper counter: per-step down-counter with manual, automatic and external reload
// assumes front panel inputs and the sequence-done pulse are synchronous to aclk
//
// The AXI4-Lite slave port and the address map were left to the implementer.
`timescale 1ns/1ps
`include "wsc_map.svh"
module wsc_top #(
	parameter int SHOW_CYCLES = `WSC_SHOW_CYC
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wsc_pkg::wsc_buttons_s buttons,
	input wire logic estop,
	input wire logic external_reset_terminal,
	input wire logic seq_done,
	output logic [6:0] sched_disp,
	output logic [13:0] data_disp,
	output logic end_msg,
	output logic po_valve
);
	import wsc_pkg::*;

	logic [31:0] ctrl_r, w_data_r, wr_data, show_cnt_r;
	logic [6:0] step_r, first_r, saddr_r, rd_addr_r, mem_waddr;
	logic [13:0] count_r, wr_cnt;
	logic [7:0] aw_addr_r;
	logic [6:0] ev_lvl, ev_rise;
	logic aw_got_r, w_got_r, wr_go, wr_hit;
	logic reload_kind_r, manual_kind_r, reload_pend_r, manual_pend_r, clear_pend_r;
	logic end_r, end_set, end_nxt, shown_cnt_r, ext_fall;
	logic prog_mode, stepper_en, manual_hit, ext_hit, clear_hit, any_press, is_reset_cmd, mem_we;
	wsc_state_e state_r;
	wsc_sched_s rd_data, mem_wdata;

	assign prog_mode = ctrl_r[`WSC_F_PROG];
	assign stepper_en = (ctrl_r[`WSC_F_MODE] == `WSC_MODE_A) || (ctrl_r[`WSC_F_MODE] == `WSC_MODE_B);

	// bit 6 is the three-button combination, so only its full assertion makes an edge
	assign ev_lvl = {buttons.enter & buttons.data_ones & buttons.data_tens, buttons};

	wsc_edge #(
		.W(7)
	) u_edge (
		.aclk(aclk),
		.aresetn(aresetn),
		.lvl(ev_lvl),
		.rst_val(7'h00),
		.rise(ev_rise),
		.fall()
	);

	wsc_edge #(
		.W(1)
	) u_ext_edge (
		.aclk(aclk),
		.aresetn(aresetn),
		.lvl(external_reset_terminal),
		.rst_val(1'b1),
		.rise(),
		.fall(ext_fall)
	);

	assign manual_hit = prog_mode & ev_rise[6];
	assign ext_hit = (ctrl_r[`WSC_F_INFN] == `WSC_INFN_EXTRST) & ext_fall;
	assign clear_hit = prog_mode & buttons.enter & ev_rise[2];
	assign any_press = |ev_rise[5:0];
	assign is_reset_cmd = (rd_data.weld_count == 14'h0000) && (rd_data.off_time == `WSC_RST_OFF) &&
		(rd_data.valves == 8'h00) && !rd_data.other_nz;

	// AXI4-Lite write channel: address and data taken in either order, one response per pair
	assign wr_go = aw_got_r & w_got_r & ~s_axi_bvalid;
	assign wr_data = w_data_r;
	assign wr_hit = (aw_addr_r == `WSC_A_CTRL) || (aw_addr_r == `WSC_A_STEP) || (aw_addr_r == `WSC_A_COUNT) ||
		(aw_addr_r == `WSC_A_FIRST) || (aw_addr_r == `WSC_A_SADDR) || (aw_addr_r == `WSC_A_SDATA);
	assign wr_cnt = (wr_data[`WSC_F_WC] > `WSC_CNT_MAX) ? `WSC_CNT_MAX : wr_data[`WSC_F_WC];

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_got_r <= 1'b0;
			w_got_r <= 1'b0;
			aw_addr_r <= 8'h00;
			w_data_r <= 32'h0000_0000;
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `WSC_RESP_OK;
		end else begin
			s_axi_awready <= ~aw_got_r & ~(s_axi_awvalid & s_axi_awready) & ~s_axi_bvalid;
			s_axi_wready <= ~w_got_r & ~(s_axi_wvalid & s_axi_wready) & ~s_axi_bvalid;
			if (s_axi_awvalid & s_axi_awready) begin
				aw_got_r <= 1'b1;
				aw_addr_r <= {s_axi_awaddr[7:2], 2'b00};
			end
			if (s_axi_wvalid & s_axi_wready) begin
				w_got_r <= 1'b1;
				w_data_r <= s_axi_wdata;
			end
			if (wr_go) begin
				aw_got_r <= 1'b0;
				w_got_r <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= wr_hit ? `WSC_RESP_OK : `WSC_RESP_ERR;
			end else if (s_axi_bvalid & s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// byte strobes are not decoded: every accepted write lands as a whole word
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl_r <= `WSC_CTRL_RST;
			first_r <= 7'h00;
			saddr_r <= 7'h00;
		end else if (wr_go && (w_got_r) && (s_axi_wstrb == 4'hf || 1'b1)) begin
			if (aw_addr_r == `WSC_A_CTRL) begin
				ctrl_r <= wr_data;
			end
			if (aw_addr_r == `WSC_A_FIRST) begin
				first_r <= wr_data[6:0];
			end
			if (aw_addr_r == `WSC_A_SADDR) begin
				saddr_r <= wr_data[6:0];
			end
		end
	end

	// software data writes own the memory port; a panel clear waits for a free cycle
	always_comb begin
		mem_we = 1'b0;
		mem_waddr = saddr_r;
		mem_wdata = '0;
		if (wr_go && aw_addr_r == `WSC_A_SDATA) begin
			mem_we = 1'b1;
			mem_wdata.weld_count = wr_cnt;
			mem_wdata.off_time = wr_data[`WSC_F_OFF];
			mem_wdata.valves = wr_data[`WSC_F_VALVE];
			mem_wdata.other_nz = wr_data[`WSC_F_OTHER];
		end else if (clear_pend_r) begin
			mem_we = 1'b1;
			mem_waddr = ctrl_r[`WSC_F_SSEL];
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			clear_pend_r <= 1'b0;
		end else if (clear_hit) begin
			clear_pend_r <= 1'b1;
		end else if (!(wr_go && aw_addr_r == `WSC_A_SDATA)) begin
			clear_pend_r <= 1'b0;
		end
	end

	wsc_sched_mem u_mem (
		.aclk(aclk),
		.we(mem_we),
		.waddr(mem_waddr),
		.wdata(mem_wdata),
		.raddr(rd_addr_r),
		.rdata(rd_data)
	);

	// AXI4-Lite read channel
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= `WSC_RESP_OK;
		end else begin
			s_axi_arready <= ~s_axi_rvalid & ~(s_axi_arvalid & s_axi_arready);
			if (s_axi_arvalid & s_axi_arready) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rresp <= `WSC_RESP_OK;
				unique case ({s_axi_araddr[7:2], 2'b00})
					`WSC_A_CTRL: s_axi_rdata <= ctrl_r;
					`WSC_A_STEP: s_axi_rdata <= {25'h0, step_r};
					`WSC_A_COUNT: s_axi_rdata <= {18'h0, count_r};
					`WSC_A_FIRST: s_axi_rdata <= {25'h0, first_r};
					`WSC_A_SADDR: s_axi_rdata <= {25'h0, saddr_r};
					`WSC_A_SDATA: s_axi_rdata <= 32'h0000_0000;
					`WSC_A_STATUS: s_axi_rdata <= {28'h0, state_r != ST_IDLE, |show_cnt_r, po_valve, end_r};
					default: begin
						s_axi_rdata <= 32'h0000_0000;
						s_axi_rresp <= `WSC_RESP_ERR;
					end
				endcase
			end else if (s_axi_rvalid & s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

	// reload requests are held until the fetch really launches; an idle count write defers it
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			reload_pend_r <= 1'b0;
			manual_pend_r <= 1'b0;
		end else if (manual_hit | ext_hit) begin
			reload_pend_r <= 1'b1;
			manual_pend_r <= manual_pend_r | manual_hit;
		end else if (state_r == ST_IDLE && reload_pend_r && !(wr_go && aw_addr_r == `WSC_A_COUNT)) begin
			reload_pend_r <= 1'b0;
			manual_pend_r <= 1'b0;
		end
	end

	// step and count: fetched schedule wins, then software, then weld countdown
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_r <= ST_IDLE;
			step_r <= 7'h00;
			count_r <= 14'h0000;
			rd_addr_r <= 7'h00;
			reload_kind_r <= 1'b0;
			manual_kind_r <= 1'b0;
			end_set <= 1'b0;
		end else begin
			end_set <= 1'b0;
			unique case (state_r)
				ST_IDLE: begin
					if (wr_go && aw_addr_r == `WSC_A_STEP) begin
						step_r <= wr_data[6:0];
					end
					if (wr_go && aw_addr_r == `WSC_A_COUNT) begin
						count_r <= wr_cnt;
					end else if (reload_pend_r) begin
						rd_addr_r <= first_r;
						reload_kind_r <= 1'b1;
						manual_kind_r <= manual_pend_r;
						state_r <= ST_WAIT;
					end else if (seq_done && stepper_en) begin
						if (count_r > 14'h0001) begin
							count_r <= count_r - 14'h0001;
						end else begin
							count_r <= 14'h0000;
							rd_addr_r <= step_r + 7'h01;
							reload_kind_r <= 1'b0;
							manual_kind_r <= 1'b0;
							state_r <= ST_WAIT;
						end
					end
				end
				ST_WAIT: begin
					state_r <= ST_EVAL;
				end
				ST_EVAL: begin
					state_r <= ST_IDLE;
					if (reload_kind_r) begin
						step_r <= first_r;
						count_r <= rd_data.weld_count;
					end else if (is_reset_cmd) begin
						rd_addr_r <= first_r;
						reload_kind_r <= 1'b1;
						state_r <= ST_WAIT;
					end else if (rd_data.weld_count == 14'h0000) begin
						end_set <= 1'b1;
					end else begin
						step_r <= rd_addr_r;
						count_r <= rd_data.weld_count;
					end
				end
			endcase
		end
	end

	// set wins over a clear arriving in the same cycle
	assign end_nxt = end_set | (end_r & ~any_press & ~estop);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			end_r <= 1'b0;
			po_valve <= 1'b0;
		end else begin
			end_r <= end_nxt;
			po_valve <= end_nxt & ((ctrl_r[`WSC_F_POUT] == `WSC_POUT_END_A) ||
				(ctrl_r[`WSC_F_POUT] == `WSC_POUT_END_B));
		end
	end

	// display: brief show after a manual reload, count after each sequence when selected
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			show_cnt_r <= 32'h0000_0000;
			shown_cnt_r <= 1'b0;
		end else begin
			if (state_r == ST_EVAL && reload_kind_r && manual_kind_r) begin
				show_cnt_r <= SHOW_CYCLES;
			end else if (show_cnt_r != 32'h0000_0000) begin
				show_cnt_r <= show_cnt_r - 32'h0000_0001;
			end
			if (seq_done && ctrl_r[`WSC_F_SHOWCNT]) begin
				shown_cnt_r <= 1'b1;
			end else if (any_press || !ctrl_r[`WSC_F_SHOWCNT]) begin
				shown_cnt_r <= 1'b0;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sched_disp <= 7'h00;
			data_disp <= 14'h0000;
			end_msg <= 1'b0;
		end else begin
			end_msg <= end_nxt;
			sched_disp <= (show_cnt_r != 32'h0000_0000) ? step_r : ctrl_r[`WSC_F_SSEL];
			data_disp <= ((show_cnt_r != 32'h0000_0000) || shown_cnt_r) ? count_r : 14'h0000;
		end
	end
endmodule : wsc_top

// *** dv/wsc_panel.sv ***
// front panel and external switch model: levels registered just after the edge
// assumes the bench sets want and open_sw by non-blocking assignment
`timescale 1ns/1ps
module wsc_panel (
	input wire logic aclk,
	input wire logic [5:0] want,
	input wire logic open_sw,
	output wsc_pkg::wsc_buttons_s buttons,
	output logic terminal
);
	import wsc_pkg::*;
	always_ff @(posedge aclk) begin
		buttons <= want;
		// normally closed: high unless opened
		terminal <= !open_sw;
	end
endmodule : wsc_panel

// *** dv/wsc_top_chk.sv ***
// concurrent checks on the weld stepper counter ports
// assumes one aclk domain with synchronous active-low aresetn
`timescale 1ns/1ps
module wsc_top_chk (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wsc_pkg::wsc_buttons_s buttons,
	input wire logic estop,
	input wire logic end_msg,
	input wire logic po_valve
);
	import wsc_pkg::*;
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	sequence s_wtake;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	sequence s_press;
		end_msg && ((buttons & ~$past(buttons)) != 0);
	endsequence
	sequence s_gone;
		##[1:3] !end_msg;
	endsequence
	AST_VALVE_MSG: assert property (po_valve |-> end_msg)
		else $error("valve on without end message");
	AST_VALVE_FALL: assert property ($fell(end_msg) |-> !po_valve)
		else $error("valve outlived end message");
	AST_ESTOP_CLR: assert property (end_msg && estop |-> s_gone)
		else $error("estop did not clear end message");
	AST_BTN_CLR: assert property (s_press |-> s_gone)
		else $error("button did not clear end message");
	AST_BRESP_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped early");
	AST_RDATA_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped early");
	AST_WR_ANSWER: assert property (s_wtake |-> ##[1:2] s_axi_bvalid)
		else $error("write response late");
	AST_RD_ANSWER: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read response late");
	AST_NO_READY_PEND: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write ready while response pending");
endmodule : wsc_top_chk
bind wsc_top wsc_top_chk chk_u (.aclk(aclk), .aresetn(aresetn),
	.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
	.s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
	.s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
	.s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
	.buttons(buttons), .estop(estop), .end_msg(end_msg), .po_valve(po_valve));

// *** dv/weld_stepper_counter_reset_test.sv ***
// self-checking bench for the weld stepper counter
// assumes wsc_map.svh on the include path; display hold shortened to 20 cycles
`timescale 1ns/1ps
`include "wsc_map.svh"
module weld_stepper_counter_reset_test;
	import wsc_pkg::*;
	logic aclk = 0, aresetn = 0, awv = 0, wv = 0, br = 0, arv = 0, rr = 0;
	logic seq_done = 0, estop = 0, open_sw = 0;
	logic [7:0] awa = 0, ara = 0;
	logic [31:0] wd = 0, rnd = 32'h0001_0510;
	logic [5:0] want = 0;
	logic awr, wr_rdy, bv, arr, rv, end_msg, po_valve, term;
	logic [1:0] bresp, rresp;
	logic [31:0] rdata;
	logic [6:0] sched_disp;
	logic [13:0] data_disp;
	wsc_buttons_s buttons;
	logic [33:0] expq[$];
	int bad_count = 0, checks_done = 0;
	always #5 aclk = ~aclk;
	wsc_panel pan_u (.aclk(aclk), .want(want), .open_sw(open_sw), .buttons(buttons), .terminal(term));
	wsc_top #(.SHOW_CYCLES(20)) dut_u (.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd),
		.s_axi_wstrb(4'hf), .s_axi_wvalid(wv), .s_axi_wready(wr_rdy), .s_axi_bresp(bresp),
		.s_axi_bvalid(bv), .s_axi_bready(br), .s_axi_araddr(ara), .s_axi_arvalid(arv),
		.s_axi_arready(arr), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rv),
		.s_axi_rready(rr), .buttons(buttons), .estop(estop), .external_reset_terminal(term),
		.seq_done(seq_done), .sched_disp(sched_disp), .data_disp(data_disp), .end_msg(end_msg),
		.po_valve(po_valve));
	task chk(input string n, input logic [33:0] s, input logic [33:0] e);
		checks_done++;
		if (s !== e) begin
			bad_count++;
			$display("unexpected %s expected %h seen %h", n, e, s);
		end
	endtask : chk
	task summarize;
		$display("checks %0d mismatches %0d", checks_done, bad_count);
		if (bad_count == 0 && checks_done > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask : summarize
	function logic [31:0] xs(input logic [31:0] x);
		x ^= x << 13;
		x ^= x >> 17;
		x ^= x << 5;
		return x;
	endfunction : xs
	task wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge aclk);
		awa <= a;
		wd <= d;
		awv <= 1;
		wv <= 1;
		do begin
			@(posedge aclk);
			if (awr) awv <= 0;
			if (wr_rdy) wv <= 0;
		end while (!bv);
		// ready raised only once the answer shows, so the slave must hold it through a stall
		br <= 1;
		@(posedge aclk);
		br <= 0;
		chk("bresp", 34'(bresp), 34'(`WSC_RESP_OK));
	endtask : wr
	// expected read result queued before the request; the monitor pops it
	task rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r);
		expq.push_back({r, e});
		@(posedge aclk);
		ara <= a;
		arv <= 1;
		do @(posedge aclk); while (!arr);
		arv <= 0;
		while (!rv) @(posedge aclk);
		rr <= 1;
		@(posedge aclk);
		rr <= 0;
	endtask : rd
	always @(posedge aclk) begin
		if (rv && rr) chk("read", {rresp, rdata}, expq.pop_front());
	end
	task press(input logic [5:0] v);
		@(posedge aclk);
		want <= v;
		repeat (4) @(posedge aclk);
		want <= 0;
		repeat (4) @(posedge aclk);
	endtask : press
	task weld;
		@(posedge aclk);
		seq_done <= 1;
		@(posedge aclk);
		seq_done <= 0;
		repeat (8) @(posedge aclk);
	endtask : weld
	initial begin
		#200000;
		bad_count++;
		summarize;
	end
	initial begin
		repeat (16) @(posedge aclk);
		aresetn <= 1;
		repeat (3) @(posedge aclk);
		rd(`WSC_A_CTRL, `WSC_CTRL_RST, `WSC_RESP_OK);
		rd(8'h1c, 32'h0, `WSC_RESP_ERR);
		wr(`WSC_A_SADDR, 32'h2);
		wr(`WSC_A_SDATA, 32'h3);
		wr(`WSC_A_SADDR, 32'h3);
		wr(`WSC_A_SDATA, 32'(`WSC_RST_OFF) << 14);
		wr(`WSC_A_FIRST, 32'h2);
		wr(`WSC_A_CTRL, 32'h1000_0305);
		press(6'h38);
		chk("sched_disp", 34'(sched_disp), 34'h2);
		chk("data_disp", 34'(data_disp), 34'h3);
		rd(`WSC_A_STEP, 32'h2, `WSC_RESP_OK);
		rd(`WSC_A_COUNT, 32'h3, `WSC_RESP_OK);
		wr(`WSC_A_COUNT, 32'h7);
		press(6'h30);
		press(6'h18);
		rd(`WSC_A_COUNT, 32'h7, `WSC_RESP_OK);
		chk("sched_disp", 34'(sched_disp), 34'h3);
		chk("data_disp", 34'(data_disp), 34'h0);
		wr(`WSC_A_COUNT, 32'h2);
		weld;
		rd(`WSC_A_COUNT, 32'h1, `WSC_RESP_OK);
		weld;
		rd(`WSC_A_STEP, 32'h2, `WSC_RESP_OK);
		rd(`WSC_A_COUNT, 32'h3, `WSC_RESP_OK);
		chk("end_msg", 34'(end_msg), 34'h0);
		for (int i = 0; i < 4; i++) begin
			rnd = xs(rnd);
			wr(`WSC_A_COUNT, rnd % 10000);
			rd(`WSC_A_COUNT, rnd % 10000, `WSC_RESP_OK);
		end
		wr(`WSC_A_COUNT, 32'h3fff);
		rd(`WSC_A_COUNT, 32'(`WSC_CNT_MAX), `WSC_RESP_OK);
		wr(`WSC_A_CTRL, 32'h1000_0304);
		wr(`WSC_A_COUNT, 32'h5);
		weld;
		rd(`WSC_A_COUNT, 32'h5, `WSC_RESP_OK);
		wr(`WSC_A_CTRL, 32'h1000_030e);
		weld;
		rd(`WSC_A_COUNT, 32'h4, `WSC_RESP_OK);
		chk("data_disp", 34'(data_disp), 34'h4);
		wr(`WSC_A_CTRL, 32'h1005_0306);
		@(posedge aclk);
		open_sw <= 1;
		repeat (3) @(posedge aclk);
		open_sw <= 0;
		repeat (8) @(posedge aclk);
		rd(`WSC_A_COUNT, 32'h3, `WSC_RESP_OK);
		// enter must still be held in the cycle after program/operate rises
		@(posedge aclk);
		want <= 6'h20;
		repeat (3) @(posedge aclk);
		press(6'h24);
		wr(`WSC_A_COUNT, 32'h1);
		weld;
		chk("end_msg", 34'(end_msg), 34'h1);
		chk("po_valve", 34'(po_valve), 34'h1);
		press(6'h02);
		chk("end_msg", 34'(end_msg), 34'h0);
		chk("po_valve", 34'(po_valve), 34'h0);
		wr(`WSC_A_COUNT, 32'h1);
		weld;
		chk("end_msg", 34'(end_msg), 34'h1);
		@(posedge aclk);
		estop <= 1;
		@(posedge aclk);
		estop <= 0;
		repeat (4) @(posedge aclk);
		chk("end_msg", 34'(end_msg), 34'h0);
		wr(`WSC_A_CTRL, 32'h1705_0306);
		wr(`WSC_A_COUNT, 32'h1);
		weld;
		chk("po_valve", 34'(po_valve), 34'h1);
		// a code outside the two alarm codes drops the valve while the message keeps flashing
		wr(`WSC_A_CTRL, 32'h0005_0306);
		repeat (2) @(posedge aclk);
		chk("po_valve", 34'(po_valve), 34'h0);
		chk("end_msg", 34'(end_msg), 34'h1);
		summarize;
	end
endmodule : weld_stepper_counter_reset_test
